// ===== design/pin_filter.sv
`timescale 1ns/1ns
// Synchronises a pin and accepts a new level only after it stays stable.
module pin_filter #(
    parameter int STABLE = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pinIn,
    output logic level
);
    logic syncA_q;
    logic syncB_q;
    logic [7:0] count_q;

    // Two-stage synchroniser; only the second stage feeds the filter.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            syncA_q <= 1'b1;
            syncB_q <= 1'b1;
        end else begin
            syncA_q <= pinIn;
            syncB_q <= syncA_q;
        end
    end

    // Counts stable samples; short pulses reset the count and are ignored.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_q <= 8'h00;
            level <= 1'b1;
        end else if (syncB_q == level) begin
            count_q <= 8'h00;
        end else if (count_q == 8'(STABLE - 1)) begin
            count_q <= 8'h00;
            level <= syncB_q;
        end else begin
            count_q <= count_q + 8'h01;
        end
    end
endmodule : pin_filter

// ===== design/wake_and_reset_status_control.sv
`timescale 1ns/1ns
module wake_and_reset_status_control #(
    parameter int POWERUP_CYCLES = wake_reset_pkg::POWERUP_CYCLES,
    parameter int WDT_CYCLES = wake_reset_pkg::WDT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic master_clear_pin_n,
    output logic master_clear_pin_out,
    output logic master_clear_pin_oe,
    input wire logic power_on_event,
    input wire logic brownout_detect,
    input wire logic regulator_enable_pin,
    input wire logic config_mismatch_event,
    input wire logic reset_instr_exec,
    input wire logic sleep_instr_exec,
    input wire logic watchdog_clear_instr,
    input wire logic clock_lost,
    input wire logic [7:0] int_flags,
    input wire logic [7:0] int_enables,
    output logic device_reset,
    output logic cpu_run,
    output logic branch_to_vector,
    output logic resume_next,
    output logic internal_rc_clock
);
    wake_reset_pkg::power_state_e state_q;
    logic [7:0] status_q;
    logic [7:0] ctrl_q;
    logic [31:0] holdCnt_q;
    logic [31:0] wdtCnt_q;
    logic [10:0] delayCnt_q;
    logic mclrLevel;
    logic regSync1_q;
    logic regSync2_q;
    logic wakeByInt_q;
    logic awSeen_q;
    logic wSeen_q;
    logic [3:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic wrFire;
    logic wdtExpire;
    logic intWake;
    logic brownOutOk;
    logic [7:0] wrMerged;
    wake_reset_pkg::reset_events_s ev;

    // Master clear pin filter with synchroniser.
    pin_filter #(
        .STABLE(wake_reset_pkg::FILTER_CYCLES)
    ) u_master_clear_pin_filter (
        .ref_clk(ref_clk),
        .rst(rst),
        .pinIn(master_clear_pin_n),
        .level(mclrLevel)
    );

    // The pin is an input only; the device never pulls it low.
    assign master_clear_pin_out = 1'b1;
    assign master_clear_pin_oe = 1'b0;

    // Regulator strap is asynchronous; two flip-flops before use.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regSync1_q <= 1'b0;
            regSync2_q <= 1'b0;
        end else begin
            regSync1_q <= regulator_enable_pin;
            regSync2_q <= regSync1_q;
        end
    end
    assign brownOutOk = regSync2_q;

    // Gather the reset events and the wake conditions.
    assign wdtExpire = (wdtCnt_q == 32'(WDT_CYCLES - 1));
    assign intWake = |(int_flags & int_enables);
    always_comb begin
        ev.powerOn = power_on_event;
        ev.brownOut = brownout_detect & brownOutOk;
        ev.cfgMismatch = config_mismatch_event;
        ev.resetInstr = reset_instr_exec && state_q == wake_reset_pkg::ST_RUN;
        ev.watchdog = wdtExpire && state_q == wake_reset_pkg::ST_RUN;
        ev.masterClear = ~mclrLevel;
    end

    // Power sequencer: run, low power, oscillator wait, CPU wait, reset hold.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= wake_reset_pkg::ST_RESET;
            holdCnt_q <= 32'h0;
            delayCnt_q <= 11'h000;
            wakeByInt_q <= 1'b0;
        end else if (|ev) begin
            // A reset wins over any wake arriving in the same cycle.
            state_q <= wake_reset_pkg::ST_RESET;
            holdCnt_q <= 32'h0;
            wakeByInt_q <= 1'b0;
        end else begin
            case (state_q)
                wake_reset_pkg::ST_RESET: begin
                    if (holdCnt_q == 32'(POWERUP_CYCLES - 1)) begin
                        state_q <= wake_reset_pkg::ST_RUN;
                    end else begin
                        holdCnt_q <= holdCnt_q + 32'h1;
                    end
                end
                wake_reset_pkg::ST_RUN: begin
                    if (sleep_instr_exec) begin
                        state_q <= wake_reset_pkg::ST_LOWPWR;
                    end
                end
                wake_reset_pkg::ST_LOWPWR: begin
                    if (intWake || wdtExpire) begin
                        wakeByInt_q <= intWake;
                        delayCnt_q <= 11'h000;
                        if (ctrl_q[wake_reset_pkg::CTRL_IDLEN] || ctrl_q[wake_reset_pkg::CTRL_EC]
                            || ctrl_q[wake_reset_pkg::CTRL_EXTERNAL_CLOCK_PLL_MODE]) begin
                            state_q <= wake_reset_pkg::ST_CPUWAIT;
                        end else begin
                            state_q <= wake_reset_pkg::ST_OSCWAIT;
                        end
                    end
                end
                wake_reset_pkg::ST_OSCWAIT: begin
                    if (delayCnt_q == 11'(wake_reset_pkg::OSC_STARTUP_CYCLES - 1)) begin
                        delayCnt_q <= 11'h000;
                        state_q <= wake_reset_pkg::ST_CPUWAIT;
                    end else begin
                        delayCnt_q <= delayCnt_q + 11'h001;
                    end
                end
                wake_reset_pkg::ST_CPUWAIT: begin
                    if (delayCnt_q == 11'(wake_reset_pkg::CPU_START_CYCLES - 1)) begin
                        state_q <= wake_reset_pkg::ST_RUN;
                    end else begin
                        delayCnt_q <= delayCnt_q + 11'h001;
                    end
                end
                default: begin
                    state_q <= wake_reset_pkg::ST_RESET;
                end
            endcase
        end
    end

    // Watchdog counter, cleared by sleep, clear and a lost clock under monitor.
    always_ff @(posedge ref_clk) begin
        if (rst || sleep_instr_exec || watchdog_clear_instr
            || (clock_lost && ctrl_q[wake_reset_pkg::CTRL_FSCM])) begin
            wdtCnt_q <= 32'h0;
        end else if (state_q == wake_reset_pkg::ST_RESET || wdtExpire) begin
            wdtCnt_q <= 32'h0;
        end else begin
            wdtCnt_q <= wdtCnt_q + 32'h1;
        end
    end

    // Internal RC clock is forced by any reset and kept until software writes the control register.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            internal_rc_clock <= 1'b1;
        end else if (|ev) begin
            internal_rc_clock <= 1'b1;
        end else if (wrFire && awAddr_q == wake_reset_pkg::ADDR_CTRL && wStrb_q[0]) begin
            internal_rc_clock <= 1'b0;
        end
    end

    // One-cycle pulses at the resumption of execution after a wake.
    always_ff @(posedge ref_clk) begin
        if (rst || |ev) begin
            branch_to_vector <= 1'b0;
            resume_next <= 1'b0;
        end else begin
            branch_to_vector <= state_q == wake_reset_pkg::ST_CPUWAIT
                && delayCnt_q == 11'(wake_reset_pkg::CPU_START_CYCLES - 1)
                && wakeByInt_q && ctrl_q[wake_reset_pkg::CTRL_GIE];
            resume_next <= state_q == wake_reset_pkg::ST_CPUWAIT
                && delayCnt_q == 11'(wake_reset_pkg::CPU_START_CYCLES - 1)
                && !(wakeByInt_q && ctrl_q[wake_reset_pkg::CTRL_GIE]);
        end
    end

    assign device_reset = state_q == wake_reset_pkg::ST_RESET;
    assign cpu_run = state_q == wake_reset_pkg::ST_RUN;

    // Status register: hardware clears win over software writes in the same cycle.
    assign wrMerged = (status_q & ~(wake_reset_pkg::STATUS_WMASK))
        | (wData_q[7:0] & wake_reset_pkg::STATUS_WMASK);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_q <= wake_reset_pkg::STATUS_RESET;
        end else begin
            if (wrFire && awAddr_q == wake_reset_pkg::ADDR_STATUS && wStrb_q[0]) begin
                status_q <= wrMerged;
            end
            if (ev.powerOn) begin
                status_q[wake_reset_pkg::BIT_PWRON] <= 1'b0;
                status_q[wake_reset_pkg::BIT_BROWN] <= 1'b0;
                status_q[wake_reset_pkg::BIT_CFGMM] <= 1'b1;
                status_q[wake_reset_pkg::BIT_RSTI] <= 1'b1;
                status_q[wake_reset_pkg::BIT_WDTO] <= 1'b1;
                status_q[wake_reset_pkg::BIT_PWDN] <= 1'b1;
            end else if (ev.brownOut) begin
                status_q[wake_reset_pkg::BIT_BROWN] <= 1'b0;
                status_q[wake_reset_pkg::BIT_CFGMM] <= 1'b1;
                status_q[wake_reset_pkg::BIT_RSTI] <= 1'b1;
                status_q[wake_reset_pkg::BIT_WDTO] <= 1'b1;
                status_q[wake_reset_pkg::BIT_PWDN] <= 1'b1;
            end else if (|ev) begin
                if (ev.cfgMismatch) begin
                    status_q[wake_reset_pkg::BIT_CFGMM] <= 1'b0;
                end
                if (ev.resetInstr) begin
                    status_q[wake_reset_pkg::BIT_RSTI] <= 1'b0;
                end
                if (ev.watchdog) begin
                    status_q[wake_reset_pkg::BIT_WDTO] <= 1'b0;
                end
                if (ev.masterClear && state_q != wake_reset_pkg::ST_RESET) begin
                    status_q[wake_reset_pkg::BIT_WDTO] <= 1'b1;
                    if (state_q == wake_reset_pkg::ST_LOWPWR) begin
                        status_q[wake_reset_pkg::BIT_PWDN] <= 1'b0;
                    end
                end
            end else if (state_q == wake_reset_pkg::ST_LOWPWR && (intWake || wdtExpire)) begin
                status_q[wake_reset_pkg::BIT_PWDN] <= 1'b0;
                if (wdtExpire && !intWake) begin
                    status_q[wake_reset_pkg::BIT_WDTO] <= 1'b0;
                end
            end else if (watchdog_clear_instr) begin
                status_q[wake_reset_pkg::BIT_WDTO] <= 1'b1;
                status_q[wake_reset_pkg::BIT_PWDN] <= 1'b1;
            end else if (sleep_instr_exec && state_q == wake_reset_pkg::ST_RUN) begin
                status_q[wake_reset_pkg::BIT_WDTO] <= 1'b1;
                status_q[wake_reset_pkg::BIT_PWDN] <= 1'b0;
            end
            if (!brownOutOk) begin
                status_q[wake_reset_pkg::BIT_BROWN] <= 1'b0;
            end
        end
    end

    // Control register write.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q <= wake_reset_pkg::CTRL_RESET;
        end else if (wrFire && awAddr_q == wake_reset_pkg::ADDR_CTRL && wStrb_q[0]) begin
            ctrl_q <= wData_q[7:0];
        end
    end

    // AXI4-Lite write channel: address and data taken in either order.
    assign s_axi_awready = !awSeen_q && !s_axi_bvalid;
    assign s_axi_wready = !wSeen_q && !s_axi_bvalid;
    assign wrFire = awSeen_q && wSeen_q && !s_axi_bvalid;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            awSeen_q <= 1'b0;
            wSeen_q <= 1'b0;
            awAddr_q <= 4'h0;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= wake_reset_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awSeen_q <= 1'b1;
                awAddr_q <= s_axi_awaddr[3:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wSeen_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrFire) begin
                awSeen_q <= 1'b0;
                wSeen_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_q == wake_reset_pkg::ADDR_STATUS
                    || awAddr_q == wake_reset_pkg::ADDR_CTRL || awAddr_q == wake_reset_pkg::ADDR_INFO)
                    ? wake_reset_pkg::RESP_OKAY : wake_reset_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel: one-cycle answer after the address is taken.
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= wake_reset_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= wake_reset_pkg::RESP_OKAY;
            case (s_axi_araddr[3:0])
                wake_reset_pkg::ADDR_STATUS: s_axi_rdata <= {24'h0, status_q};
                wake_reset_pkg::ADDR_CTRL: s_axi_rdata <= {24'h0, ctrl_q};
                wake_reset_pkg::ADDR_INFO: s_axi_rdata <= {29'h0, state_q};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= wake_reset_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : wake_and_reset_status_control

// ===== design/wake_reset_pkg.sv
package wake_reset_pkg;
    // Register byte addresses on the AXI4-Lite slave.
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_INFO = 4'h8;
    // Field positions of the reset cause status register.
    localparam int BIT_PRIO = 7;
    localparam int BIT_CFGMM = 5;
    localparam int BIT_RSTI = 4;
    localparam int BIT_WDTO = 3;
    localparam int BIT_PWDN = 2;
    localparam int BIT_PWRON = 1;
    localparam int BIT_BROWN = 0;
    // Writable bits and reset value of the status register.
    localparam logic [7:0] STATUS_WMASK = 8'hBF;
    localparam logic [7:0] STATUS_RESET = 8'h3C;
    // Control register fields.
    localparam int CTRL_GIE = 0;
    localparam int CTRL_EC = 1;
    localparam int CTRL_EXTERNAL_CLOCK_PLL_MODE = 2;
    localparam int CTRL_FSCM = 3;
    localparam int CTRL_IDLEN = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Timing: clock period, CPU start delay, start-up timer, power-up delay.
    localparam int CLK_PERIOD_NS = 50;
    localparam int CPU_START_DELAY_NS = 200;
    localparam int CPU_START_CYCLES = (CPU_START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_STARTUP_CYCLES = 1024;
    localparam int POWERUP_DELAY_US = 66000;
    localparam int POWERUP_CYCLES = POWERUP_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int FILTER_CYCLES = 4;
    localparam int WDT_CYCLES = 4000;
    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_LOWPWR = 3'h1,
        ST_OSCWAIT = 3'h3,
        ST_CPUWAIT = 3'h2,
        ST_RESET = 3'h6
    } power_state_e;

    // Reset cause events gathered in one cycle.
    typedef struct packed {
        logic powerOn;
        logic brownOut;
        logic cfgMismatch;
        logic resetInstr;
        logic watchdog;
        logic masterClear;
    } reset_events_s;
endpackage : wake_reset_pkg

// ===== sim/wake_and_reset_status_control_tb.sv
`timescale 1ns/1ns
// Drives the block over its bus and event pins and judges the answers.
module wake_and_reset_status_control_tb;
    localparam int PUP = 20;
    localparam int WDT = 3000;
    localparam int CPU = wake_reset_pkg::CPU_START_CYCLES;
    localparam int OSC = wake_reset_pkg::OSC_STARTUP_CYCLES;
    localparam logic [31:0] ST = {28'h0, wake_reset_pkg::ADDR_STATUS};
    localparam logic [31:0] CT = {28'h0, wake_reset_pkg::ADDR_CTRL};
    logic ref_clk = 1'b0, rst = 1'b1, regEn = 1'b1, mclrN = 1'b1, wdClr = 1'b0, rcAtRun;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, pinOut, pinOe, devRst, cpuRun, br, rs, rcClk;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] ev = 6'h0;
    logic [7:0] intFlags = 8'h0, intEn = 8'h0;
    int miscompares = 0, total_checks = 0, brCnt = 0, rsCnt = 0, rstCnt = 0, n;

    wake_and_reset_status_control #(.POWERUP_CYCLES(PUP), .WDT_CYCLES(WDT)) i_wake_and_reset_status_control (
        .ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .master_clear_pin_n(mclrN),
        .master_clear_pin_out(pinOut), .master_clear_pin_oe(pinOe), .power_on_event(ev[0]),
        .brownout_detect(ev[1]), .regulator_enable_pin(regEn), .config_mismatch_event(ev[2]),
        .reset_instr_exec(ev[3]), .sleep_instr_exec(ev[4]), .watchdog_clear_instr(wdClr),
        .clock_lost(ev[5]), .int_flags(intFlags), .int_enables(intEn), .device_reset(devRst),
        .cpu_run(cpuRun), .branch_to_vector(br), .resume_next(rs), .internal_rc_clock(rcClk));

    // Makes the 20 MHz clock.
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // Counts pulses and reset cycles.
    always @(negedge ref_clk) begin
        brCnt += (br === 1'b1);
        rsCnt += (rs === 1'b1);
        rstCnt += (devRst === 1'b1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One bus transfer.
    task automatic axi(input logic wr, input logic [31:0] a, d, input logic [1:0] r,
                       output logic [31:0] rd);
        logic pa, pw, ta, tw, tr;
        logic [1:0] rsp;
        pa = 1'b1;
        pw = wr;
        tr = 1'b0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        while (!tr) begin
            @(negedge ref_clk);
            ta = pa && (wr ? s_axi_awready : s_axi_arready);
            tw = pw && s_axi_wready;
            tr = !pa && !pw && (wr ? s_axi_bvalid : s_axi_rvalid);
            rsp = wr ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            @(posedge ref_clk);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (tw) s_axi_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        check({30'h0, rsp}, {30'h0, r});
    endtask : axi

    task automatic wreg(input logic [31:0] a, d);
        logic [31:0] x;
        axi(1'b1, a, d, wake_reset_pkg::RESP_OKAY, x);
    endtask : wreg

    task automatic rchk(input logic [31:0] a, e);
        logic [31:0] x;
        axi(1'b0, a, 32'h0, wake_reset_pkg::RESP_OKAY, x);
        check(x, e);
    endtask : rchk

    task automatic pulse(input logic [5:0] m);
        ev <= m;
        @(posedge ref_clk);
        ev <= 6'h0;
    endtask : pulse

    // Waits for Run and notes the clock.
    task automatic waitRun(output int k);
        k = 0;
        @(negedge ref_clk);
        while (cpuRun !== 1'b1) begin
            k++;
            @(negedge ref_clk);
        end
        rcAtRun = rcClk;
        @(posedge ref_clk);
    endtask : waitRun

    // Power-on, brown-out, config mismatch and reset instruction each clear their own flag.
    task automatic causeTest;
        logic [5:0] m [4] = '{6'h01, 6'h02, 6'h04, 6'h08};
        logic [7:0] e [4] = '{8'h3C, 8'h3E, 8'h1F, 8'h2F};
        logic [31:0] x;
        for (int i = 0; i < 4; i++) begin
            wreg(ST, 32'h3F);
            wreg(CT, 32'h0);
            pulse(m[i]);
            waitRun(n);
            check(32'(n >= PUP), 32'h1);
            check({31'h0, rcAtRun}, 32'h1);
            rchk(ST, {24'h0, e[i]});
        end
        axi(1'b0, 32'hC, 32'h0, wake_reset_pkg::RESP_SLVERR, x);
        check(x, 32'h0);
        axi(1'b1, 32'hC, 32'h0, wake_reset_pkg::RESP_SLVERR, x);
        pulse(6'h02);
        repeat (10) @(posedge ref_clk);
        pulse(6'h02);
        waitRun(n);
        check(32'(n >= PUP), 32'h1);
    endtask : causeTest

    // Regulator off and master clear filter.
    task automatic pinTest;
        int c0;
        regEn <= 1'b0;
        wreg(ST, 32'h3F);
        c0 = rstCnt;
        pulse(6'h02);
        repeat (PUP) @(posedge ref_clk);
        check(rstCnt - c0, 32'h0);
        rchk(ST, 32'h3E);
        regEn <= 1'b1;
        mclrN <= 1'b0;
        repeat (2) @(posedge ref_clk);
        mclrN <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check(rstCnt - c0, 32'h0);
        mclrN <= 1'b0;
        repeat (30) @(posedge ref_clk);
        check(32'(rstCnt - c0 >= 20), 32'h1);
        mclrN <= 1'b1;
        waitRun(n);
        rchk(ST, 32'h3E);
    endtask : pinTest

    // Sleeps, wakes and times the exit.
    task automatic wakeTest(input logic [31:0] c, input logic byInt, input int lo, hi,
                            input logic [7:0] es);
        wreg(CT, c);
        wreg(ST, 32'h3F);
        intEn <= 8'h04;
        pulse(6'h10);
        brCnt = 0;
        rsCnt = 0;
        repeat (3) @(posedge ref_clk);
        intFlags <= {5'h0, byInt, 2'h0};
        waitRun(n);
        intFlags <= 8'h0;
        repeat (3) @(posedge ref_clk);
        check(32'(n >= lo && n <= hi), 32'h1);
        check(brCnt, {31'h0, c[0] & byInt});
        check(brCnt + rsCnt, 32'h1);
        rchk(ST, {24'h0, es});
    endtask : wakeTest

    // Watchdog resets in Run; a lost clock with the monitor on clears it.
    task automatic watchdogTest;
        int c0;
        wreg(ST, 32'h3F);
        wreg(CT, 32'h08);
        c0 = rstCnt;
        for (int i = 0; i < 4; i++) begin
            repeat (WDT / 2) @(posedge ref_clk);
            wdClr <= i[0];
            pulse({!i[0], 5'h0});
            wdClr <= 1'b0;
        end
        check(rstCnt - c0, 32'h0);
        wreg(CT, 32'h0);
        repeat (WDT + 10) @(posedge ref_clk);
        waitRun(n);
        check(32'(rstCnt > c0), 32'h1);
        rchk(ST, 32'h37);
        wreg(CT, 32'h11);
        wreg(ST, 32'h3F);
        pulse(6'h10);
        repeat (3) @(posedge ref_clk);
        brCnt = 0;
        intFlags <= 8'h04;
        pulse(6'h04);
        waitRun(n);
        intFlags <= 8'h0;
        check(brCnt, 32'h0);
        rchk(ST, 32'h1B);
    endtask : watchdogTest

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // Cuts a hang short.
    initial begin
        #(50 * 60000);
        miscompares++;
        complete_run();
    end

    // Main sequence.
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        waitRun(n);
        check(32'(n >= PUP), 32'h1);
        rchk(ST, {24'h0, wake_reset_pkg::STATUS_RESET});
        rchk(CT, 32'h0);
        wreg(ST, 32'hFF);
        rchk(ST, 32'hBF);
        causeTest();
        pinTest();
        wakeTest(32'h11, 1'b1, CPU, CPU + 3, 8'h3B);
        wakeTest(32'h10, 1'b1, CPU, CPU + 3, 8'h3B);
        wakeTest(32'h03, 1'b1, CPU, CPU + 3, 8'h3B);
        wakeTest(32'h04, 1'b1, CPU, CPU + 3, 8'h3B);
        wakeTest(32'h00, 1'b1, OSC, OSC + CPU + 4, 8'h3B);
        wakeTest(32'h10, 1'b0, WDT - 5, WDT + 10, 8'h33);
        watchdogTest();
        complete_run();
    end
endmodule : wake_and_reset_status_control_tb

// ===== sim/wake_reset_sva.sv
`timescale 1ns/1ns
// Watches the block's ports.
module wake_reset_sva #(
    parameter int POWERUP_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic master_clear_pin_out,
    input wire logic master_clear_pin_oe,
    input wire logic reset_instr_exec,
    input wire logic sleep_instr_exec,
    input wire logic device_reset,
    input wire logic cpu_run,
    input wire logic branch_to_vector,
    input wire logic internal_rc_clock
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [31:0] holdCnt_q;
    // Counts the cycles spent in the reset hold.
    always_ff @(posedge ref_clk) begin
        if (rst || !device_reset) begin
            holdCnt_q <= 32'h0;
        end else begin
            holdCnt_q <= holdCnt_q + 32'h1;
        end
    end
    sequence bWait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence rWait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    pin_undriven_a: assert property (!master_clear_pin_oe && master_clear_pin_out)
        else $error("master clear pin driven");
    run_reset_excl_a: assert property (!(cpu_run && device_reset))
        else $error("run during reset hold");
    bresp_hold_a: assert property (bWait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    rdata_hold_a: assert property (rWait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while answering");
    rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    instr_reset_a: assert property (cpu_run && reset_instr_exec |=> device_reset)
        else $error("reset instruction ignored");
    rc_clock_a: assert property ($rose(device_reset) |-> ##[0:2] internal_rc_clock)
        else $error("internal clock not selected");
    powerup_hold_a: assert property ($fell(device_reset) |-> holdCnt_q >= POWERUP_CYCLES - 1)
        else $error("reset hold too short");
    sleep_exit_a: assert property (cpu_run && sleep_instr_exec |=> !cpu_run)
        else $error("sleep not entered");
    branch_pulse_a: assert property (branch_to_vector |-> cpu_run ##1 !branch_to_vector)
        else $error("vector pulse wrong");
endmodule : wake_reset_sva

bind wake_and_reset_status_control wake_reset_sva #(.POWERUP_CYCLES(POWERUP_CYCLES)) i_wake_reset_sva (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .master_clear_pin_out(master_clear_pin_out),
    .master_clear_pin_oe(master_clear_pin_oe), .reset_instr_exec(reset_instr_exec),
    .sleep_instr_exec(sleep_instr_exec), .device_reset(device_reset), .cpu_run(cpu_run),
    .branch_to_vector(branch_to_vector), .internal_rc_clock(internal_rc_clock));
